// ==== rtl/wscr_pkg.sv ====
// Package: offsets, field layouts, reset and fail-safe patterns of the wake control registers
package wscr_pkg;

  // ****************************************************************
  // Register offsets on the serial control port
  // ****************************************************************
  localparam logic [6:0] WSCR_ADDR_INT = 7'h06;
  localparam logic [6:0] WSCR_ADDR_EXT = 7'h07;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int WSCR_INT_TIMER_B_BIT = 7;
  localparam int WSCR_INT_TIMER_A_BIT = 6;
  localparam int WSCR_INT_WD_UP_BIT   = 2;
  localparam int WSCR_EXT_GLOBAL_BIT  = 7;
  localparam int WSCR_EXT_MEAS_BIT    = 5;
  localparam int WSCR_EXT_PIN3_BIT    = 2;
  localparam int WSCR_EXT_PIN2_BIT    = 1;
  localparam int WSCR_EXT_PIN1_BIT    = 0;
  localparam int WSCR_PIN_COUNT       = 3;
  localparam int WSCR_SRC_COUNT       = 5;

  // ****************************************************************
  // Implemented bits, reset and restart patterns
  // ****************************************************************
  localparam logic [7:0] WSCR_INT_RW_MASK      = 8'hC4;
  localparam logic [7:0] WSCR_EXT_RW_MASK      = 8'hA7;
  localparam logic [7:0] WSCR_INT_RESET        = 8'h00;
  localparam logic [7:0] WSCR_EXT_RESET        = 8'h07;
  localparam logic [7:0] WSCR_INT_RESTART_KEEP = 8'hC0;
  localparam logic [7:0] WSCR_EXT_RESTART_KEEP = 8'hA7;

  // ****************************************************************
  // Fail-safe patterns: keep mask and forced value per register
  // ****************************************************************
  localparam logic [7:0] WSCR_FS_EXT_KEEP  = 8'hA0;
  localparam logic [7:0] WSCR_FS_EXT_VAL   = 8'h07;
  localparam logic [7:0] WSCR_FS_BUS1_KEEP = 8'hE0;
  localparam logic [7:0] WSCR_FS_BUS1_VAL  = 8'h09;
  localparam logic [7:0] WSCR_FS_BUS2_KEEP = 8'h00;
  localparam logic [7:0] WSCR_FS_BUS2_VAL  = 8'h01;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } wscr_req_t;

  typedef struct packed {
    logic       timer_b_wake_en;
    logic       timer_a_wake_en;
    logic       stop_wd_off_upper;
    logic       int_global;
    logic       meas_sel;
    logic [2:0] pin_wake_en;
  } wscr_cfg_t;

endpackage

// ==== rtl/wscr_sync.sv ====
// Two-flop synchroniser for the high-voltage wake pin levels
`timescale 1ns/1ns
module wscr_sync
  import wscr_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WSCR_PIN_COUNT-1:0] async_i,
  output logic      [WSCR_PIN_COUNT-1:0] sync_o
);

  logic [WSCR_PIN_COUNT-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// ==== rtl/wscr_wake_qual.sv ====
// Wake source qualification and interrupt trigger policy
`timescale 1ns/1ns
module wscr_wake_qual
  import wscr_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  // Configuration and raw events
  input  wire wscr_cfg_t                 cfg_i,
  input  wire logic [WSCR_PIN_COUNT-1:0] pin_sync_i,
  input  wire logic                      timer_a_tick_i,
  input  wire logic                      timer_b_tick_i,
  input  wire logic                      status_event_i,
  // Qualified results
  output logic [WSCR_SRC_COUNT-1:0]      wake_src_o,
  output logic                           wake_event_o,
  output logic                           int_trigger_o
);

  logic [WSCR_PIN_COUNT-1:0] pin_prev;
  logic [WSCR_PIN_COUNT-1:0] pin_rise;
  logic [WSCR_PIN_COUNT-1:0] pin_en_eff;
  logic [WSCR_SRC_COUNT-1:0] next_src;

  // Measurement use takes pins one and two out of the wake path [RL6]
  assign pin_en_eff = cfg_i.pin_wake_en & {1'b1, ~cfg_i.meas_sel, ~cfg_i.meas_sel};
  assign pin_rise   = pin_sync_i & ~pin_prev;
  // Pin and timer wakes pass only when enabled [RL1] [RL2] [RL8]
  assign next_src   = {timer_b_tick_i & cfg_i.timer_b_wake_en,
                       timer_a_tick_i & cfg_i.timer_a_wake_en,
                       pin_rise & pin_en_eff};

  // Previous pin level for rising-edge wake detection
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_sync_i;
    end
  end

  // Wakes always interrupt; other status only under global policy [RL5]
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wake_src_o    <= '0;
      wake_event_o  <= 1'b0;
      int_trigger_o <= 1'b0;
    end else begin
      wake_src_o    <= next_src;
      wake_event_o  <= |next_src;
      int_trigger_o <= (|next_src) | (status_event_i & cfg_i.int_global);
    end
  end

endmodule

// ==== rtl/wscr_regs.sv ====
// Wake source control register pair with fail-safe and restart handling
//
// Functional notes
// RL1 - Bit 7 enables second cyclic timer wake
// RL2 - Bit 6 enables first cyclic timer wake
// RL3 - Bit 2 stop watchdog upper, device updatable
// RL4 - Reserved bits always read as zero
// RL5 - Global bit: all status raises interrupt
// RL6 - Measure select ignores pin one/two enables
// RL7 - Measure runs in normal mode; host ignores
// RL8 - Bits 2..0 enable wake pins three..one
// RL9 - Bus wakes use bus control modes
// RL10 - Fail-safe forces wake-enabling patterns
// RL11 - Internal register reset zero; restart keeps timers
// RL12 - External register reset 07; restart keeps fields
// RL13 - Writes to reserved bits are ignored
`timescale 1ns/1ns
module wscr_regs
  import wscr_pkg::*;
(
  // Clock and reset (power-on or soft reset)
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  // Register access from the serial port decoder
  input  wire wscr_req_t                 req_i,
  output logic [7:0]                     rdata_o,
  output logic                           rvalid_o,
  // Device mode events
  input  wire logic                      restart_i,
  input  wire logic                      fail_safe_entry_i,
  input  wire logic                      normal_mode_i,
  // Device update of the stop watchdog upper bit
  input  wire logic                      wd_upper_we_i,
  input  wire logic                      wd_upper_val_i,
  // Wake and status sources
  input  wire logic [WSCR_PIN_COUNT-1:0] wake_pin_i,
  input  wire logic                      timer_a_tick_i,
  input  wire logic                      timer_b_tick_i,
  input  wire logic                      status_event_i,
  // Configuration and results
  output wscr_cfg_t                      cfg_o,
  output logic [WSCR_SRC_COUNT-1:0]      wake_src_o,
  output logic                           wake_event_o,
  output logic                           int_trigger_o,
  output logic                           measure_run_o,
  output logic                           bus_ctrl_force_o
);

  // ****************************************************************
  // Storage and decode
  // ****************************************************************
  logic [7:0]                int_reg;
  logic [7:0]                ext_reg;
  logic [7:0]                next_int;
  logic [WSCR_PIN_COUNT-1:0] pin_sync;
  logic                      wr_int;
  logic                      wr_ext;

  // Shared address match used by write and read paths
  function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // Read mux, unmapped addresses return zero
  function automatic logic [7:0] read_mux(input logic [6:0] a,
                                          input logic [7:0] ri,
                                          input logic [7:0] re);
    read_mux = 8'h00;
    if (addr_hit(a, WSCR_ADDR_INT)) begin
      read_mux = ri & WSCR_INT_RW_MASK;
    end else if (addr_hit(a, WSCR_ADDR_EXT)) begin
      read_mux = re & WSCR_EXT_RW_MASK;
    end
  endfunction

  assign wr_int = req_i.wr & addr_hit(req_i.addr, WSCR_ADDR_INT);
  assign wr_ext = req_i.wr & addr_hit(req_i.addr, WSCR_ADDR_EXT);

  // ****************************************************************
  // Internal wake register
  // ****************************************************************

  // Host write merged with device update; device update wins the bit
  always_comb begin
    next_int = int_reg;
    if (wr_int) begin
      next_int = req_i.wdata & WSCR_INT_RW_MASK; // [RL1] [RL2] [RL13]
    end
    if (wd_upper_we_i) begin
      next_int[WSCR_INT_WD_UP_BIT] = wd_upper_val_i; // [RL3]
    end
  end

  // Restart outranks writes so a stale write cannot survive it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      int_reg <= WSCR_INT_RESET; // [RL11]
    end else if (restart_i) begin
      int_reg <= int_reg & WSCR_INT_RESTART_KEEP; // [RL11]
    end else begin
      int_reg <= next_int;
    end
  end

  // ****************************************************************
  // External wake register
  // ****************************************************************

  // Fail-safe first: the device must stay wakeable whatever the host did
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ext_reg <= WSCR_EXT_RESET; // [RL12]
    end else if (fail_safe_entry_i) begin
      ext_reg <= (ext_reg & WSCR_FS_EXT_KEEP) | WSCR_FS_EXT_VAL; // [RL10]
    end else if (restart_i) begin
      ext_reg <= ext_reg & WSCR_EXT_RESTART_KEEP; // [RL12]
    end else if (wr_ext) begin
      ext_reg <= req_i.wdata & WSCR_EXT_RW_MASK; // [RL5] [RL6] [RL8] [RL13]
    end
  end

  // Bus control registers live elsewhere; they take their patterns on this pulse
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bus_ctrl_force_o <= 1'b0;
    end else begin
      bus_ctrl_force_o <= fail_safe_entry_i; // [RL10]
    end
  end

  // ****************************************************************
  // Read path and configuration view
  // ****************************************************************

  // Registered read data, reserved positions forced low
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= read_mux(req_i.addr, int_reg, ext_reg); // [RL4]
      end
    end
  end

  // Field view of the stored bits
  assign cfg_o.timer_b_wake_en   = int_reg[WSCR_INT_TIMER_B_BIT];
  assign cfg_o.timer_a_wake_en   = int_reg[WSCR_INT_TIMER_A_BIT];
  assign cfg_o.stop_wd_off_upper = int_reg[WSCR_INT_WD_UP_BIT];
  assign cfg_o.int_global        = ext_reg[WSCR_EXT_GLOBAL_BIT];
  assign cfg_o.meas_sel          = ext_reg[WSCR_EXT_MEAS_BIT];
  assign cfg_o.pin_wake_en       = {ext_reg[WSCR_EXT_PIN3_BIT],
                                    ext_reg[WSCR_EXT_PIN2_BIT],
                                    ext_reg[WSCR_EXT_PIN1_BIT]};

  // Measurement only runs in normal mode; pin level status is then meaningless
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      measure_run_o <= 1'b0;
    end else begin
      measure_run_o <= cfg_o.meas_sel & normal_mode_i; // [RL7]
    end
  end

  // ****************************************************************
  // Wake path
  // ****************************************************************
  wscr_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (wake_pin_i),
    .sync_o     (pin_sync)
  );

  wscr_wake_qual u_qual (
    .core_clk_i     (core_clk_i),
    .rst_n_i        (rst_n_i),
    .cfg_i          (cfg_o),
    .pin_sync_i     (pin_sync),
    .timer_a_tick_i (timer_a_tick_i),
    .timer_b_tick_i (timer_b_tick_i),
    .status_event_i (status_event_i),
    .wake_src_o     (wake_src_o),
    .wake_event_o   (wake_event_o),
    .int_trigger_o  (int_trigger_o)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // One clock domain, so clocking and reset qualification are given once
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_timer_b_write;
    wr_int && !restart_i |=> cfg_o.timer_b_wake_en == $past(req_i.wdata[7]);
  endproperty
  a_timer_b_write: assert property (p_timer_b_write) // [RL1]
    else $error("timer b wake enable not written");

  property p_timer_a_gate;
    timer_a_tick_i && !cfg_o.timer_a_wake_en |=> !wake_src_o[3];
  endproperty
  a_timer_a_gate: assert property (p_timer_a_gate) // [RL2]
    else $error("disabled timer a produced a wake");

  property p_wd_update;
    wd_upper_we_i && !restart_i |=> cfg_o.stop_wd_off_upper == $past(wd_upper_val_i);
  endproperty
  a_wd_update: assert property (p_wd_update) // [RL3]
    else $error("device update of watchdog bit lost");

  property p_reserved_read;
    rvalid_o |-> ((rdata_o & ~WSCR_INT_RW_MASK) == 8'h00) || ($past(req_i.addr) != WSCR_ADDR_INT);
  endproperty
  a_reserved_read: assert property (p_reserved_read) // [RL4]
    else $error("reserved bit read as one");

  property p_int_policy;
    int_trigger_o |-> wake_event_o || $past(status_event_i && cfg_o.int_global);
  endproperty
  a_int_policy: assert property (p_int_policy) // [RL5]
    else $error("interrupt without a permitted cause");

  property p_meas_ignore;
    cfg_o.meas_sel && $past(cfg_o.meas_sel) |=> wake_src_o[1:0] == 2'b00;
  endproperty
  a_meas_ignore: assert property (p_meas_ignore) // [RL6]
    else $error("pin one or two woke under measurement");

  property p_meas_run;
    ##1 measure_run_o == $past(cfg_o.meas_sel && normal_mode_i);
  endproperty
  a_meas_run: assert property (p_meas_run) // [RL7]
    else $error("measurement run state wrong");

  property p_pin3_gate;
    wake_src_o[2] |-> $past(cfg_o.pin_wake_en[2]);
  endproperty
  a_pin3_gate: assert property (p_pin3_gate) // [RL8]
    else $error("pin three woke while disabled");

  property p_fail_safe;
    fail_safe_entry_i |=> ((ext_reg & ~WSCR_FS_EXT_KEEP) == WSCR_FS_EXT_VAL)
      && ((((ext_reg ^ $past(ext_reg)) & WSCR_FS_EXT_KEEP)) == 8'h00)
      && bus_ctrl_force_o;
  endproperty
  a_fail_safe: assert property (p_fail_safe) // [RL10]
    else $error("fail-safe pattern not applied");

  property p_restart_int;
    restart_i |=> int_reg[5:0] == 6'h00 && int_reg[7:6] == $past(int_reg[7:6]);
  endproperty
  a_restart_int: assert property (p_restart_int) // [RL11]
    else $error("internal register restart wrong");

  property p_restart_ext;
    restart_i && !fail_safe_entry_i |=> ext_reg == ($past(ext_reg) & WSCR_EXT_RESTART_KEEP);
  endproperty
  a_restart_ext: assert property (p_restart_ext) // [RL12]
    else $error("external register restart wrong");

  property p_reserved_write;
    wr_ext |=> (ext_reg & ~WSCR_EXT_RW_MASK) == 8'h00;
  endproperty
  a_reserved_write: assert property (p_reserved_write) // [RL13]
    else $error("reserved bit stored by a write");

  property p_reserved_read_ext;
    rvalid_o && $past(req_i.addr) == WSCR_ADDR_EXT |-> (rdata_o & ~WSCR_EXT_RW_MASK) == 8'h00;
  endproperty
  a_reserved_read_ext: assert property (p_reserved_read_ext) // [RL4]
    else $error("reserved external bit read as one");

  property p_pin1_gate;
    wake_src_o[0] |-> $past(cfg_o.pin_wake_en[0] && !cfg_o.meas_sel);
  endproperty
  a_pin1_gate: assert property (p_pin1_gate) // [RL6] [RL8]
    else $error("pin one woke while disabled or measuring");

  property p_wake_interrupts;
    wake_event_o |-> int_trigger_o;
  endproperty
  a_wake_interrupts: assert property (p_wake_interrupts) // [RL5]
    else $error("wake event raised no interrupt");

  property p_bus_force_pulse;
    bus_ctrl_force_o |-> $past(fail_safe_entry_i);
  endproperty
  a_bus_force_pulse: assert property (p_bus_force_pulse) // [RL10]
    else $error("bus control force without fail-safe entry");

  // Main scenarios the bench is expected to reach
  c_restart:    cover property (restart_i ##1 cfg_o.timer_b_wake_en);
  c_write_int:  cover property (wr_int ##1 cfg_o.timer_b_wake_en);
  c_fail_safe:  cover property (fail_safe_entry_i ##1 bus_ctrl_force_o);
  c_measure:    cover property (cfg_o.meas_sel && normal_mode_i ##1 measure_run_o);
  c_global_int: cover property (status_event_i && cfg_o.int_global ##1 int_trigger_o);

endmodule

// ==== tb/wscr_host.sv ====
// Host controller model issuing single register reads and writes
`timescale 1ns/1ns
module wscr_host
  import wscr_pkg::*;
(
  // Clock
  input  wire logic       core_clk_i,
  // Register port towards the device
  output wscr_req_t       req_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  // Idle request; data is inverted after use so stale values never look valid
  initial begin
    req_o = '0;
  end

  // One-cycle write strobe; never touches bus control registers
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One-cycle read strobe; answer taken one cycle later
  // Pin level status is never consulted while measuring
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge core_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: req_o.wdata};
    @(negedge core_clk_i);
    v = rvalid_i;
    d = rdata_i;
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req_o.wdata};
  endtask
endmodule

// ==== tb/wscr_regs_tb_top.sv ====
// Self-checking bench for the wake source control registers
`timescale 1ns/1ns
module wscr_regs_tb_top
  import wscr_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       clk;
  logic       rst_n;
  wscr_req_t  req;
  logic [7:0] rdata;
  logic       rvalid;
  logic       rst_ev;
  logic       fs;
  logic       nm;
  logic       wd_we;
  logic       wd_val;
  logic [2:0] pins;
  logic       tka;
  logic       tkb;
  logic       st;
  wscr_cfg_t  cfg;
  logic [4:0] src;
  logic       wev;
  logic       intr;
  logic       mrun;
  logic       bforce;
  int         n_errors;
  int         n_checks;

  wscr_regs i_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .restart_i(rst_ev), .fail_safe_entry_i(fs),
    .normal_mode_i(nm), .wd_upper_we_i(wd_we), .wd_upper_val_i(wd_val),
    .wake_pin_i(pins), .timer_a_tick_i(tka), .timer_b_tick_i(tkb),
    .status_event_i(st), .cfg_o(cfg), .wake_src_o(src), .wake_event_o(wev),
    .int_trigger_o(intr), .measure_run_o(mrun), .bus_ctrl_force_o(bforce)
  );

  wscr_host i_host (
    .core_clk_i(clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid)
  );

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string nme, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nme, exp, seen);
    end
  endtask

  // Read and compare data plus the valid pulse
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_host.rd(a, d, v);
    check("rvalid", {7'h00, v}, 8'h01);
    check("rdata", d, exp);
  endtask

  // Event pulse: 0 timer a, 1 timer b, 2 status, 3 restart, 4 fail-safe, 5 wd
  task automatic ev(input int k);
    @(negedge clk);
    {wd_we, fs, rst_ev, st, tkb, tka} <= 6'(1 << k);
    @(negedge clk);
    {wd_we, fs, rst_ev, st, tkb, tka} <= 6'h00;
  endtask

  // Gather pulses over a window wide enough for the pin synchroniser
  task automatic obs(input logic [4:0] es, input logic ei);
    logic [4:0] s;
    logic       i;
    logic       w;
    s = src;
    i = intr;
    w = wev;
    repeat (6) begin
      @(negedge clk);
      s |= src;
      i |= intr;
      w |= wev;
    end
    check("wake_src", {3'h0, s}, {3'h0, es});
    check("int_trigger", {7'h00, i}, {7'h00, ei});
    check("wake_event", {7'h00, w}, {7'h00, |es});
  endtask

  task automatic setpins(input logic [2:0] p);
    @(negedge clk);
    pins <= p;
  endtask

  task automatic results();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the roughly 140 cycles of the sequence
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    results();
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    {wd_we, fs, rst_ev, st, tkb, tka} = 6'h00;
    nm = 1'b0;
    wd_val = 1'b0;
    pins = 3'h0;
    repeat (3) @(negedge clk);
    rst_n <= 1'b1;
    rdchk(WSCR_ADDR_INT, 8'h00);
    rdchk(WSCR_ADDR_EXT, 8'h07);
    rdchk(7'h3F, 8'h00);
    // All ones to both registers, then an unmapped zero write that must not land
    i_host.wr(WSCR_ADDR_INT, 8'hFF);
    i_host.wr(WSCR_ADDR_EXT, 8'hFF);
    i_host.wr(7'h3F, 8'h00);
    check("cfg", cfg, 8'hFF);
    rdchk(WSCR_ADDR_INT, 8'hC4);
    rdchk(WSCR_ADDR_EXT, 8'hA7);
    // Restart keeps timer wakes and external fields
    ev(3);
    rdchk(WSCR_ADDR_INT, 8'hC0);
    rdchk(WSCR_ADDR_EXT, 8'hA7);
    wd_val = 1'b1;
    ev(5);
    rdchk(WSCR_ADDR_INT, 8'hC4);
    // Timer wakes enabled, then disabled
    ev(0);
    obs(5'h08, 1'b1);
    ev(1);
    obs(5'h10, 1'b1);
    i_host.wr(WSCR_ADDR_INT, 8'h00);
    ev(0);
    obs(5'h00, 1'b0);
    ev(1);
    obs(5'h00, 1'b0);
    // Measurement selected: pins one and two ignored
    nm = 1'b1;
    repeat (3) @(negedge clk);
    check("measure_run", {7'h00, mrun}, 8'h01);
    setpins(3'h7);
    obs(5'h04, 1'b1);
    setpins(3'h0);
    obs(5'h00, 1'b0);
    ev(2);
    obs(5'h00, 1'b1);
    // Wake-only interrupt policy, pins as wake inputs
    i_host.wr(WSCR_ADDR_EXT, 8'h07);
    ev(2);
    obs(5'h00, 1'b0);
    check("measure_run", {7'h00, mrun}, 8'h00);
    setpins(3'h7);
    obs(5'h07, 1'b1);
    setpins(3'h0);
    obs(5'h00, 1'b0);
    i_host.wr(WSCR_ADDR_EXT, 8'h01);
    setpins(3'h3);
    obs(5'h01, 1'b1);
    setpins(3'h0);
    // Fail-safe entry re-enables pin wakes, keeps policy bits
    i_host.wr(WSCR_ADDR_EXT, 8'hA0);
    ev(4);
    check("bus_ctrl_force", {7'h00, bforce}, 8'h01);
    rdchk(WSCR_ADDR_EXT, 8'hA7);
    // Soft reset mid-run restores both reset patterns
    ev(5);
    @(negedge clk);
    rst_n <= 1'b0;
    repeat (3) @(negedge clk);
    rst_n <= 1'b1;
    rdchk(WSCR_ADDR_INT, 8'h00);
    rdchk(WSCR_ADDR_EXT, 8'h07);
    check("measure_run", {7'h00, mrun}, 8'h00);
    results();
  end
endmodule
